/* core/pad_mux_pkg.sv */
// constants for the pad function and pull-up control block
`default_nettype none
package pad_mux_pkg;
   // port d register bit positions
   localparam int PD_LINE_ONE_BIT   = 1;
   localparam int PD_LINE_SIX_BIT   = 6;
   localparam int PD_LINE_SEVEN_BIT = 7;
   // port e register bit positions
   localparam int PE_LINE_ZERO_BIT  = 0;
   localparam int PE_LINE_ONE_BIT   = 1;
   // system pin-select bit that steers the port d line one pad
   localparam int PIN_SEL_FUNC_BIT    = 5;
   // register widths
   localparam int PORT_WIDTH = 16;
   localparam int PIN_SEL_WIDTH = 16;
   // reset values: all pull-ups on, all gpio peripheral enables clear
   localparam logic [15:0] PULLUP_RESET  = 16'hFFFF;
   localparam logic [15:0] PER_EN_RESET  = 16'h0000;
   localparam logic [15:0] PIN_SEL_RESET = 16'h0000;
   // pin-select value 0 gives chip select three, 1 gives can receive
   localparam logic PIN_SEL_CHIP_SELECT = 1'b0;
   // tap state codes; test data out is driven only in the two shift states
   typedef enum logic [3:0] {
      TAP_OTHER    = 4'h0,
      TAP_SHIFT_DR = 4'h4,
      TAP_SHIFT_IR = 4'hB
   } tap_state_t;
endpackage
`default_nettype wire

/* core/pad_mux_if.sv */
// pad signals shared between top and test-pin pad module
`default_nettype none
interface test_pad_if;
   logic tck_edge_rise;
   logic tck_edge_fall;
   logic tms_sample;
   logic tdi_sample;
   logic tdo_value;
   logic tdo_oe;
   logic tap_shift;
   logic tdo_data;
   modport top (output tck_edge_rise, output tck_edge_fall,
                output tap_shift, output tdo_data,
                input tms_sample, input tdi_sample,
                input tdo_value, input tdo_oe);
   modport pad (input tck_edge_rise, input tck_edge_fall,
                input tap_shift, input tdo_data,
                output tms_sample, output tdi_sample,
                output tdo_value, output tdo_oe);
endinterface
`default_nettype wire

/* core/test_pad_ctrl.sv */
// test access pads: sampling and test data out drive
`default_nettype none
module test_pad_ctrl
   import pad_mux_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   input  wire logic tms_pad_i,
   input  wire logic tdi_pad_i,
   test_pad_if.pad   tp
);
   logic tms_r;
   logic tdi_r;
   logic tdo_r;
   logic tdo_oe_r;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         tms_r <= 1'b1;
         tdi_r <= 1'b1;
      end else if (tp.tck_edge_rise) begin
         tms_r <= tms_pad_i; // RULE_14
         tdi_r <= tdi_pad_i; // RULE_14
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (tp.tck_edge_fall) begin
         tdo_r    <= tp.tdo_data;  // RULE_15
         tdo_oe_r <= tp.tap_shift; // RULE_15
      end
   end

   assign tp.tms_sample = tms_r;
   assign tp.tdi_sample = tdi_r;
   assign tp.tdo_value  = tdo_r;
   assign tp.tdo_oe     = tdo_oe_r;
endmodule // test_pad_ctrl
`default_nettype wire

/* core/pad_function_and_pullup_control.sv */
// pad function selection and pull-up control for multiplexed pins
// What this block does
// RULE_01 - after reset port d line one pad is gpio input with pull-up
// RULE_02 - peripheral enable bit 1 hands pad over; pin-select bit 5 picks function
// RULE_03 - chip select pad floats while bus idle unless drive-keep bit set
// RULE_04 - software should set bus drive-keep to 1 to avoid floating select
// RULE_05 - can receive pad path has internal pull-up
// RULE_06 - port d pull-up bit 1 controls line one pad pull-up
// RULE_07 - both serial transmit pads default to serial transmit after reset
// RULE_08 - port e pull-up bit 0 controls serial zero transmit pull-up
// RULE_09 - port e pull-up bit 1 controls serial zero receive pull-up
// RULE_10 - port d pull-up bit 6 controls serial one transmit pull-up
// RULE_11 - serial one receive pad defaults to serial receive input
// RULE_12 - port d pull-up bit 7 controls serial one receive pull-up
// RULE_13 - test clock pulled down; jtag disable bit drops tms/tdi pull-ups
// RULE_14 - tms and tdi sampled on test clock rising edge
// RULE_15 - tdo driven only in shift states, changes on test clock fall
// RULE_16 - with peripheral enable clear, port d line one pad follows gpio port logic only
`default_nettype none
module pad_function_and_pullup_control
   import pad_mux_pkg::*;
(
   input  wire logic                     core_clk_i,
   input  wire logic                     reset_i,
   // configuration writes
   input  wire logic                     cfg_we_i,
   input  wire logic [PORT_WIDTH-1:0]    port_d_peripheral_enable_i,
   input  wire logic [PORT_WIDTH-1:0]    port_e_peripheral_enable_i,
   input  wire logic [PIN_SEL_WIDTH-1:0] system_pin_select_i,
   input  wire logic [PORT_WIDTH-1:0]    port_d_pullup_enable_i,
   input  wire logic [PORT_WIDTH-1:0]    port_e_pullup_enable_i,
   input  wire logic                     jtag_pullup_disable_i,
   input  wire logic                     bus_drive_keep_i,
   // readback
   output logic [PORT_WIDTH-1:0]         port_d_peripheral_enable_o,
   output logic [PORT_WIDTH-1:0]         port_e_peripheral_enable_o,
   output logic [PIN_SEL_WIDTH-1:0]      system_pin_select_o,
   output logic [PORT_WIDTH-1:0]         port_d_pullup_enable_o,
   output logic [PORT_WIDTH-1:0]         port_e_pullup_enable_o,
   output logic                          jtag_pullup_disable_o,
   // gpio port logic
   input  wire logic [PORT_WIDTH-1:0]    gpio_d_out_i,
   input  wire logic [PORT_WIDTH-1:0]    gpio_d_oe_i,
   input  wire logic [PORT_WIDTH-1:0]    gpio_e_out_i,
   input  wire logic [PORT_WIDTH-1:0]    gpio_e_oe_i,
   output logic [PORT_WIDTH-1:0]         gpio_d_in_o,
   output logic [PORT_WIDTH-1:0]         gpio_e_in_o,
   // peripherals
   input  wire logic                     chip_select_three_n_i,
   input  wire logic                     bus_active_i,
   output logic                          can_two_receive_o,
   input  wire logic                     serial_zero_transmit_i,
   output logic                          serial_zero_receive_o,
   input  wire logic                     serial_one_transmit_i,
   output logic                          serial_one_receive_o,
   // pads: port d line one, serial pads
   input  wire logic                     port_d_line_one_i,
   output logic                          port_d_line_one_o,
   output logic                          port_d_line_one_oe_o,
   output logic                          port_d_line_one_pu_o,
   input  wire logic                     port_e_line_zero_i,
   output logic                          port_e_line_zero_o,
   output logic                          port_e_line_zero_oe_o,
   output logic                          port_e_line_zero_pu_o,
   input  wire logic                     port_e_line_one_i,
   output logic                          port_e_line_one_o,
   output logic                          port_e_line_one_oe_o,
   output logic                          port_e_line_one_pu_o,
   input  wire logic                     port_d_line_six_i,
   output logic                          port_d_line_six_o,
   output logic                          port_d_line_six_oe_o,
   output logic                          port_d_line_six_pu_o,
   input  wire logic                     port_d_line_seven_i,
   output logic                          port_d_line_seven_o,
   output logic                          port_d_line_seven_oe_o,
   output logic                          port_d_line_seven_pu_o,
   // test access pads
   input  wire logic                     tck_pad_i,
   input  wire logic                     tms_pad_i,
   input  wire logic                     tdi_pad_i,
   input  wire logic [3:0]               tap_state_i,
   input  wire logic                     tdo_data_i,
   output logic                          tck_pd_o,
   output logic                          tms_pu_o,
   output logic                          tdi_pu_o,
   output logic                          tms_sample_o,
   output logic                          tdi_sample_o,
   output logic                          tdo_o,
   output logic                          tdo_oe_o
);
   logic [PORT_WIDTH-1:0]    d_per_r;
   logic [PORT_WIDTH-1:0]    e_per_r;
   logic [PIN_SEL_WIDTH-1:0] pin_sel_r;
   logic [PORT_WIDTH-1:0]    d_pu_r;
   logic [PORT_WIDTH-1:0]    e_pu_r;
   logic                     jtag_pud_r;
   logic                     drive_keep_r;
   logic                     tck_prev_r;
   logic                     line_one_per;
   logic                     line_one_can;
   logic                     cs_oe;
   logic [1:0]               tx_zero_drive;
   logic [1:0]               tx_one_drive;
   logic [2:0]               rx_zero_route;
   logic [2:0]               rx_one_route;

   test_pad_if tp ();

   // pad lines and the function bit must fit inside the registers
   if (PORT_WIDTH <= PD_LINE_SEVEN_BIT) begin : g_port_width_check
      $error("port width too narrow for the pad lines");
   end
   if (PIN_SEL_WIDTH <= PIN_SEL_FUNC_BIT) begin : g_sel_width_check
      $error("pin-select width too narrow for the function bit");
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         d_per_r   <= PER_EN_RESET; // RULE_01
         pin_sel_r <= PIN_SEL_RESET;
      end else if (cfg_we_i) begin
         d_per_r   <= port_d_peripheral_enable_i;
         pin_sel_r <= system_pin_select_i;
      end
   end

   // serial pads come up owned by the serial ports
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         e_per_r <= PER_EN_RESET;
      end else if (cfg_we_i) begin
         e_per_r <= port_e_peripheral_enable_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         d_pu_r     <= PULLUP_RESET;
         e_pu_r     <= PULLUP_RESET;
         jtag_pud_r <= 1'b0;
      end else if (cfg_we_i) begin
         d_pu_r     <= port_d_pullup_enable_i;
         e_pu_r     <= port_e_pullup_enable_i;
         jtag_pud_r <= jtag_pullup_disable_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         drive_keep_r <= 1'b0;
      end else if (cfg_we_i) begin
         drive_keep_r <= bus_drive_keep_i; // RULE_04
      end
   end

   assign port_d_peripheral_enable_o = d_per_r;
   assign port_e_peripheral_enable_o = e_per_r;
   assign system_pin_select_o        = pin_sel_r;
   assign port_d_pullup_enable_o     = d_pu_r;
   assign port_e_pullup_enable_o     = e_pu_r;
   assign jtag_pullup_disable_o      = jtag_pud_r;

   // port d line one: gpio, chip select three or can receive
   assign line_one_per = d_per_r[PD_LINE_ONE_BIT]; // RULE_02
   assign line_one_can = line_one_per &&
      (pin_sel_r[PIN_SEL_FUNC_BIT] != PIN_SEL_CHIP_SELECT); // RULE_02
   assign cs_oe = bus_active_i || drive_keep_r; // RULE_03

   always_comb begin
      if (!line_one_per) begin
         port_d_line_one_o    = gpio_d_out_i[PD_LINE_ONE_BIT]; // RULE_16
         port_d_line_one_oe_o = gpio_d_oe_i[PD_LINE_ONE_BIT];  // RULE_16
      end else if (line_one_can) begin
         port_d_line_one_o    = 1'b0;
         port_d_line_one_oe_o = 1'b0;
      end else begin
         port_d_line_one_o    = chip_select_three_n_i;
         port_d_line_one_oe_o = cs_oe; // RULE_03
      end
   end
   assign port_d_line_one_pu_o = d_pu_r[PD_LINE_ONE_BIT]; // RULE_06
   // undriven receive line reads recessive high through the pull-up
   assign can_two_receive_o = line_one_can ? port_d_line_one_i
                                           : 1'b1; // RULE_05

   // transmit pad: serial transmit unless handed to gpio, floats in reset
   function automatic logic [1:0] tx_pad_drive(
      input logic gpio_sel,
      input logic gpio_out,
      input logic gpio_oe,
      input logic tx,
      input logic in_reset
   );
      logic [1:0] drive;
      drive = 2'h0;
      if (in_reset) begin
         drive = 2'h0;
      end else if (gpio_sel) begin
         drive = {gpio_oe, gpio_out};
      end else begin
         drive = {1'b1, tx};
      end
      return drive;
   endfunction

   // receive pad: gpio drives only when handed over, receive idles high
   function automatic logic [2:0] rx_pad_route(
      input logic gpio_sel,
      input logic gpio_out,
      input logic gpio_oe,
      input logic pad_level
   );
      logic [2:0] route;
      route = 3'h0;
      if (gpio_sel) begin
         route = {1'b1, gpio_oe, gpio_out};
      end else begin
         route = {pad_level, 1'b0, gpio_out};
      end
      return route;
   endfunction

   // serial zero pads on port e lines zero and one
   assign tx_zero_drive = tx_pad_drive(
      e_per_r[PE_LINE_ZERO_BIT],
      gpio_e_out_i[PE_LINE_ZERO_BIT],
      gpio_e_oe_i[PE_LINE_ZERO_BIT],
      serial_zero_transmit_i,
      reset_i
   ); // RULE_07
   assign port_e_line_zero_o    = tx_zero_drive[0];
   assign port_e_line_zero_oe_o = tx_zero_drive[1]; // RULE_07
   assign port_e_line_zero_pu_o = e_pu_r[PE_LINE_ZERO_BIT]; // RULE_08
   assign rx_zero_route = rx_pad_route(
      e_per_r[PE_LINE_ONE_BIT],
      gpio_e_out_i[PE_LINE_ONE_BIT],
      gpio_e_oe_i[PE_LINE_ONE_BIT],
      port_e_line_one_i
   ); // RULE_09
   assign port_e_line_one_o     = rx_zero_route[0];
   assign port_e_line_one_oe_o  = rx_zero_route[1]; // RULE_09
   assign port_e_line_one_pu_o  = e_pu_r[PE_LINE_ONE_BIT]; // RULE_09
   assign serial_zero_receive_o = rx_zero_route[2]; // RULE_09

   // serial one pads on port d lines six and seven
   assign tx_one_drive = tx_pad_drive(
      d_per_r[PD_LINE_SIX_BIT],
      gpio_d_out_i[PD_LINE_SIX_BIT],
      gpio_d_oe_i[PD_LINE_SIX_BIT],
      serial_one_transmit_i,
      reset_i
   ); // RULE_07
   assign port_d_line_six_o     = tx_one_drive[0];
   assign port_d_line_six_oe_o  = tx_one_drive[1]; // RULE_07
   assign port_d_line_six_pu_o  = d_pu_r[PD_LINE_SIX_BIT]; // RULE_10
   assign rx_one_route = rx_pad_route(
      d_per_r[PD_LINE_SEVEN_BIT],
      gpio_d_out_i[PD_LINE_SEVEN_BIT],
      gpio_d_oe_i[PD_LINE_SEVEN_BIT],
      port_d_line_seven_i
   ); // RULE_11
   assign port_d_line_seven_o    = rx_one_route[0];
   assign port_d_line_seven_oe_o = rx_one_route[1]; // RULE_11
   assign port_d_line_seven_pu_o = d_pu_r[PD_LINE_SEVEN_BIT]; // RULE_12
   assign serial_one_receive_o   = rx_one_route[2]; // RULE_11

   // gpio input readback
   always_comb begin
      gpio_d_in_o = '0;
      gpio_e_in_o = '0;
      gpio_d_in_o[PD_LINE_ONE_BIT]   = port_d_line_one_i;
      gpio_d_in_o[PD_LINE_SIX_BIT]   = port_d_line_six_i;
      gpio_d_in_o[PD_LINE_SEVEN_BIT] = port_d_line_seven_i;
      gpio_e_in_o[PE_LINE_ZERO_BIT]  = port_e_line_zero_i;
      gpio_e_in_o[PE_LINE_ONE_BIT]   = port_e_line_one_i;
   end

   // test access pads
   assign tck_pd_o = 1'b1;         // RULE_13
   assign tms_pu_o = !jtag_pud_r;  // RULE_13
   assign tdi_pu_o = !jtag_pud_r;  // RULE_13

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         tck_prev_r <= 1'b0;
      end else begin
         tck_prev_r <= tck_pad_i;
      end
   end

   assign tp.tck_edge_rise = tck_pad_i && !tck_prev_r; // RULE_14
   assign tp.tck_edge_fall = !tck_pad_i && tck_prev_r; // RULE_15
   assign tp.tdo_data      = tdo_data_i;

   always_comb begin
      case (tap_state_t'(tap_state_i))
         TAP_SHIFT_DR: tp.tap_shift = 1'b1; // RULE_15
         TAP_SHIFT_IR: tp.tap_shift = 1'b1; // RULE_15
         default:      tp.tap_shift = 1'b0;
      endcase
   end

   test_pad_ctrl u_test_pad (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .tms_pad_i  (tms_pad_i),
      .tdi_pad_i  (tdi_pad_i),
      .tp         (tp)
   );

   assign tms_sample_o = tp.tms_sample;
   assign tdi_sample_o = tp.tdi_sample;
   assign tdo_o        = tp.tdo_value;
   assign tdo_oe_o     = tp.tdo_oe;
endmodule // pad_function_and_pullup_control
`default_nettype wire

/* test/pad_board_model.sv */
// board-side model of the five shared pads
`default_nettype none
module pad_board_model (
   input  wire logic       core_clk_i,
   input  wire logic [4:0] ext_en_i, ext_v_i, oe_i, o_i, pu_i,
   output logic      [4:0] lvl_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] last_r;
   // outside driver wins, then pad driver, then pull-up, else drifts
   assign lvl_o = (ext_en_i & ext_v_i) | (~ext_en_i & oe_i & o_i)
      | (~ext_en_i & ~oe_i & pu_i)
      | (~ext_en_i & ~oe_i & ~pu_i & ~last_r);
   always_ff @(posedge core_clk_i) last_r <= lvl_o;
endmodule // pad_board_model
`default_nettype wire

/* test/pad_function_and_pullup_control_assertions.sv */
// assertions on the pad control ports
`default_nettype none
module pad_checker
   import pad_mux_pkg::*;
(
   input wire logic core_clk_i, reset_i, tck_pad_i, tms_pad_i, tdi_pad_i,
   input wire logic tdo_data_i, tdo_o, tdo_oe_o, tms_sample_o, tdi_sample_o,
   input wire logic [3:0] tap_state_i,
   input wire logic [15:0] port_d_pullup_enable_o, port_e_pullup_enable_o,
   input wire logic [15:0] port_d_peripheral_enable_o, system_pin_select_o,
   input wire logic [15:0] gpio_d_oe_i, gpio_d_out_i,
   input wire logic port_d_line_one_o, port_d_line_one_oe_o,
   input wire logic port_d_line_one_pu_o, port_e_line_zero_pu_o,
   input wire logic port_e_line_one_pu_o, port_d_line_six_pu_o,
   input wire logic port_d_line_seven_pu_o, jtag_pullup_disable_o,
   input wire logic tck_pd_o, tms_pu_o, tdi_pu_o,
   input wire logic bus_active_i, chip_select_three_n_i
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_rise; !tck_pad_i ##1 tck_pad_i; endsequence
   sequence s_fall; tck_pad_i ##1 !tck_pad_i; endsequence
   property p_rst_d1;
      $fell(reset_i) |-> port_d_line_one_pu_o && !port_d_line_one_oe_o;
   endproperty
   a_rst_d1: assert property (p_rst_d1) else $error("d1 reset");
   property p_cs_drive;
      port_d_peripheral_enable_o[1] && !system_pin_select_o[5] && bus_active_i
      |-> port_d_line_one_oe_o && port_d_line_one_o == chip_select_three_n_i;
   endproperty
   a_cs_drive: assert property (p_cs_drive) else $error("cs drive");
   property p_pu_d1; port_d_line_one_pu_o == port_d_pullup_enable_o[1];
   endproperty
   a_pu_d1: assert property (p_pu_d1) else $error("d1 pull");
   property p_pu_e0; port_e_line_zero_pu_o == port_e_pullup_enable_o[0];
   endproperty
   a_pu_e0: assert property (p_pu_e0) else $error("e0 pull");
   property p_pu_e1; port_e_line_one_pu_o == port_e_pullup_enable_o[1];
   endproperty
   a_pu_e1: assert property (p_pu_e1) else $error("e1 pull");
   property p_pu_d6; port_d_line_six_pu_o == port_d_pullup_enable_o[6];
   endproperty
   a_pu_d6: assert property (p_pu_d6) else $error("d6 pull");
   property p_pu_d7; port_d_line_seven_pu_o == port_d_pullup_enable_o[7];
   endproperty
   a_pu_d7: assert property (p_pu_d7) else $error("d7 pull");
   property p_jtag_pull;
      tck_pd_o && tms_pu_o == !jtag_pullup_disable_o
      && tdi_pu_o == !jtag_pullup_disable_o;
   endproperty
   a_jtag_pull: assert property (p_jtag_pull) else $error("jtag pull");
   property p_sample;
      s_rise |=> tms_sample_o == $past(tms_pad_i)
      && tdi_sample_o == $past(tdi_pad_i);
   endproperty
   a_sample: assert property (p_sample) else $error("tms tdi sample");
   property p_tdo_fall;
      s_fall |=> tdo_o == $past(tdo_data_i) && tdo_oe_o ==
      ($past(tap_state_i) == TAP_SHIFT_DR || $past(tap_state_i) == TAP_SHIFT_IR);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo fall");
   property p_gpio_d1;
      !port_d_peripheral_enable_o[1] |-> port_d_line_one_oe_o == gpio_d_oe_i[1]
      && port_d_line_one_o == gpio_d_out_i[1];
   endproperty
   a_gpio_d1: assert property (p_gpio_d1) else $error("d1 gpio");
endmodule // pad_checker
`default_nettype wire

/* test/pad_function_and_pullup_control_test.sv */
// testbench for the pad function and pull-up control block
`default_nettype none
module pad_function_and_pullup_control_test
   import pad_mux_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i, reset_i, cfg_we_i, jtag_pullup_disable_i;
   logic bus_drive_keep_i, chip_select_three_n_i, bus_active_i;
   logic serial_zero_transmit_i, serial_one_transmit_i, tck_pad_i;
   logic tms_pad_i, tdi_pad_i, tdo_data_i;
   logic [3:0] tap_state_i;
   logic [15:0] port_d_peripheral_enable_i, port_e_peripheral_enable_i;
   logic [15:0] system_pin_select_i, port_d_pullup_enable_i;
   logic [15:0] port_e_pullup_enable_i, gpio_d_out_i, gpio_d_oe_i;
   logic [15:0] gpio_e_out_i, gpio_e_oe_i, port_d_peripheral_enable_o;
   logic [15:0] port_e_peripheral_enable_o, system_pin_select_o;
   logic [15:0] port_d_pullup_enable_o, port_e_pullup_enable_o;
   logic [15:0] gpio_d_in_o, gpio_e_in_o;
   logic jtag_pullup_disable_o, can_two_receive_o, serial_zero_receive_o;
   logic serial_one_receive_o, tck_pd_o, tms_pu_o, tdi_pu_o, tms_sample_o;
   logic tdi_sample_o, tdo_o, tdo_oe_o;
   logic port_d_line_one_i, port_d_line_one_o, port_d_line_one_oe_o;
   logic port_d_line_one_pu_o, port_e_line_zero_i, port_e_line_zero_o;
   logic port_e_line_zero_oe_o, port_e_line_zero_pu_o, port_e_line_one_i;
   logic port_e_line_one_o, port_e_line_one_oe_o, port_e_line_one_pu_o;
   logic port_d_line_six_i, port_d_line_six_o, port_d_line_six_oe_o;
   logic port_d_line_six_pu_o, port_d_line_seven_i, port_d_line_seven_o;
   logic port_d_line_seven_oe_o, port_d_line_seven_pu_o;
   logic [4:0] ext_en, ext_v;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   pad_function_and_pullup_control dut (.*);
   pad_board_model brd (.core_clk_i(core_clk_i), .ext_en_i(ext_en),
      .ext_v_i(ext_v),
      .oe_i({port_d_line_seven_oe_o, port_d_line_six_oe_o,
         port_e_line_one_oe_o, port_e_line_zero_oe_o, port_d_line_one_oe_o}),
      .o_i({port_d_line_seven_o, port_d_line_six_o, port_e_line_one_o,
         port_e_line_zero_o, port_d_line_one_o}),
      .pu_i({port_d_line_seven_pu_o, port_d_line_six_pu_o,
         port_e_line_one_pu_o, port_e_line_zero_pu_o, port_d_line_one_pu_o}),
      .lvl_o({port_d_line_seven_i, port_d_line_six_i, port_e_line_one_i,
         port_e_line_zero_i, port_d_line_one_i}));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cfg(logic [15:0] per, sel, dpu, epu, logic jd, keep);
      @(posedge core_clk_i);
      cfg_we_i <= 1'b1;
      port_d_peripheral_enable_i <= per;
      system_pin_select_i <= sel;
      port_d_pullup_enable_i <= dpu;
      port_e_pullup_enable_i <= epu;
      jtag_pullup_disable_i <= jd;
      bus_drive_keep_i <= keep;
      @(posedge core_clk_i);
      cfg_we_i <= 1'b0;
      #1;
   endtask
   task automatic t_reset;
      chk("d1 oe", 0, port_d_line_one_oe_o);
      chk("d1 level", 1, gpio_d_in_o[1]);
      chk("tx0 pad", 0, port_e_line_zero_i);
      chk("tx1 pad", 0, port_d_line_six_i);
      chk("rx1", 0, serial_one_receive_o);
      chk("rx0", 0, serial_zero_receive_o);
      chk("tdo oe reset", 0, tdo_oe_o);
      @(posedge core_clk_i);
      gpio_d_oe_i <= 16'h0002;
      #1;
      chk("d1 gpio drive", 0, gpio_d_in_o[1]);
      chk("d1 cs unused", 1, port_d_line_one_oe_o);
      gpio_d_oe_i <= 16'h0000;
      $display("test reset done");
   endtask
   task automatic t_cs;
      cfg(16'h0002, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0);
      chk("cs idle oe", 0, port_d_line_one_oe_o);
      @(posedge core_clk_i);
      bus_active_i <= 1'b1;
      chip_select_three_n_i <= 1'b0;
      #1;
      chk("cs level", 0, gpio_d_in_o[1]);
      bus_active_i <= 1'b0;
      chip_select_three_n_i <= 1'b1;
      cfg(16'h0002, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0, 1'b1);
      chk("cs kept oe", 1, port_d_line_one_oe_o);
      $display("test chip select done");
   endtask
   task automatic t_can;
      cfg(16'h0002, 16'h0020, 16'hFFFF, 16'hFFFF, 1'b0, 1'b1);
      chk("can oe", 0, port_d_line_one_oe_o);
      chk("sel readback", 16'h0020, system_pin_select_o);
      chk("can idle", 1, can_two_receive_o);
      @(posedge core_clk_i);
      ext_en <= 5'b10101;
      #1;
      chk("can low", 0, can_two_receive_o);
      ext_en <= 5'b10100;
      $display("test can done");
   endtask
   task automatic t_gpio;
      @(posedge core_clk_i);
      port_e_peripheral_enable_i <= 16'h0003;
      cfg(16'h00C0, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0);
      chk("e per readback", 16'h0003, port_e_peripheral_enable_o);
      chk("tx0 gpio oe", 0, port_e_line_zero_oe_o);
      chk("tx1 gpio oe", 0, port_d_line_six_oe_o);
      chk("e gpio in", 16'h0001, gpio_e_in_o);
      chk("rx0 gpio", 1, serial_zero_receive_o);
      chk("rx1 gpio", 1, serial_one_receive_o);
      @(posedge core_clk_i);
      gpio_e_oe_i <= 16'h0001;
      #1;
      chk("e0 gpio drive", 16'h0000, gpio_e_in_o);
      port_e_peripheral_enable_i <= 16'h0000;
      gpio_e_oe_i <= 16'h0000;
      $display("test serial gpio done");
   endtask
   task automatic t_pull;
      cfg(16'h0000, 16'h0000, 16'hFF3D, 16'hFFFC, 1'b1, 1'b0);
      chk("d1 pu", 0, port_d_line_one_pu_o);
      chk("e0 pu", 0, port_e_line_zero_pu_o);
      chk("e1 pu", 0, port_e_line_one_pu_o);
      chk("d6 pu", 0, port_d_line_six_pu_o);
      chk("d7 pu", 0, port_d_line_seven_pu_o);
      chk("tms tdi pu", 0, tms_pu_o | tdi_pu_o);
      chk("tck pd", 1, tck_pd_o);
      chk("d pu readback", 16'hFF3D, port_d_pullup_enable_o);
      chk("e pu readback", 16'hFFFC, port_e_pullup_enable_o);
      chk("jtag readback", 1, jtag_pullup_disable_o);
      $display("test pull-ups done");
   endtask
   task automatic t_tck(logic m, d, logic [3:0] st);
      @(posedge core_clk_i);
      tms_pad_i <= m;
      tdi_pad_i <= d;
      tdo_data_i <= d;
      tap_state_i <= st;
      tck_pad_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk("tms sample", m, tms_sample_o);
      chk("tdi sample", d, tdi_sample_o);
      tms_pad_i <= ~m;
      tck_pad_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      chk("tms held", m, tms_sample_o);
      chk("tdo", d, tdo_o);
      chk("tdo oe", st == TAP_SHIFT_DR || st == TAP_SHIFT_IR, tdo_oe_o);
      $display("test test clock done");
   endtask
   initial begin
      reset_i = 1'b1;
      cfg_we_i = 1'b0;
      {port_d_peripheral_enable_i, port_e_peripheral_enable_i} = '0;
      {system_pin_select_i, port_d_pullup_enable_i} = '0;
      {port_e_pullup_enable_i, gpio_d_out_i, gpio_d_oe_i} = '0;
      {gpio_e_out_i, gpio_e_oe_i, tap_state_i} = '0;
      {jtag_pullup_disable_i, bus_drive_keep_i, bus_active_i} = '0;
      {serial_zero_transmit_i, serial_one_transmit_i, tdo_data_i} = '0;
      {tck_pad_i, tms_pad_i, tdi_pad_i} = '0;
      chip_select_three_n_i = 1'b1;
      ext_en = 5'b10100;
      ext_v = 5'b00000;
      repeat (16) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      t_reset();
      t_cs();
      t_can();
      t_gpio();
      t_pull();
      t_tck(1'b0, 1'b1, TAP_SHIFT_DR);
      t_tck(1'b1, 1'b0, TAP_OTHER);
      t_tck(1'b1, 1'b1, TAP_SHIFT_IR);
      give_verdict();
   end
endmodule // pad_function_and_pullup_control_test
bind pad_function_and_pullup_control pad_checker checks (.*);
`default_nettype wire
